// ---- shared/energy_pkg.sv ----
// Purpose: constants, register map and carriers of the energy accumulator
// Assumes: 40 MHz core clock, 32-bit register port, word addressed by 4
// Notes:   command registers sit at command code times four
package energy_pkg;
  localparam int          CLK_HZ      = 40_000_000;
  localparam int          MS_DIV      = 1000;
  localparam int          T_EOUT_MS   = 50;
  localparam int          T_EIN_MS    = 100;
  localparam int          EOUT_CYC    = CLK_HZ / MS_DIV * T_EOUT_MS;
  localparam int          EIN_MAX_CYC = CLK_HZ / MS_DIV * T_EIN_MS;
  localparam logic [2:0]  AC_CYCLES   = 3'h4;
  localparam logic [5:0]  DIV_LAST    = 6'h1F;

  localparam int          AW = 10;
  localparam int          DW = 32;
  localparam logic [7:0]  CMD_VOUT_MODE = 8'h20;
  localparam logic [7:0]  CMD_COEFF     = 8'h30;
  localparam logic [7:0]  CMD_CML       = 8'h7E;
  localparam logic [7:0]  CMD_READ_EIN  = 8'h86;
  localparam logic [7:0]  CMD_READ_EOUT = 8'h87;
  localparam logic [7:0]  CMD_READ_VOUT = 8'h8B;
  localparam logic [7:0]  CMD_EFF_HL    = 8'hAB;
  localparam logic [AW-1:0] A_VOUT_MODE = {CMD_VOUT_MODE, 2'h0};
  localparam logic [AW-1:0] A_COEFF     = {CMD_COEFF, 2'h0};
  localparam logic [AW-1:0] A_CML       = {CMD_CML, 2'h0};
  localparam logic [AW-1:0] A_EIN       = {CMD_READ_EIN, 2'h0};
  localparam logic [AW-1:0] A_EOUT      = {CMD_READ_EOUT, 2'h0};
  localparam logic [AW-1:0] A_VOUT      = {CMD_READ_VOUT, 2'h0};
  localparam logic [AW-1:0] A_EFF_HL    = {CMD_EFF_HL, 2'h0};
  localparam logic [AW-1:0] A_LIN_IN    = 10'h3E0;
  localparam logic [AW-1:0] A_LIN_OUT   = 10'h3E4;
  localparam logic [AW-1:0] A_EIN_N     = 10'h3E8;
  localparam logic [AW-1:0] A_EOUT_N    = 10'h3EC;
  localparam logic [AW-1:0] A_STATUS    = 10'h3F0;
  localparam logic [AW-1:0] A_MASK      = 10'h3F4;

  localparam logic [7:0]  COEF_M       = 8'h01;
  localparam logic [7:0]  COEF_R       = 8'h00;
  localparam logic [7:0]  COEF_B       = 8'h00;
  localparam logic [2:0]  MODE_LINEAR  = 3'h0;
  localparam logic [4:0]  VOUT_EXP     = 5'h17;
  localparam logic [7:0]  BLK_COUNT    = 8'h06;
  localparam logic [14:0] ACC_MAX      = 15'h7FFF;
  localparam int          CML_INVALID  = 6;
  localparam logic [3:0]  EFF_LAST     = 4'hD;
  localparam int          EFF_BYTES    = 14;
  localparam int          ST_EIN       = 0;
  localparam int          ST_EOUT      = 1;
  localparam int          ST_CML       = 2;
  localparam int          NST          = 3;
  localparam logic [7:0]  EFF_DEFAULT [EFF_BYTES] = '{default: 8'h00};

  typedef struct packed {
    logic [AW-1:0] addr;
    logic [DW-1:0] wdata;
    logic          wr;
    logic          rd;
  } reg_req_t;

  typedef struct packed {
    logic          valid;
    logic [14:0]   power;
  } sample_t;

  typedef enum logic [0:0] {DIV_IDLE, DIV_RUN} div_state_t;
endpackage : energy_pkg

// ---- rtl/energy_accum.sv ----
// Purpose: input/output energy accumulators with latched read-back
// Assumes: power samples arrive as strobes on core_clk; line_zc is a pin
// Notes:   register port answers every read one cycle later
//
// Implementation choices: the address-and-strobe port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module energy_accum
  import energy_pkg::*;
#(
  parameter int EOUT_WIN  = EOUT_CYC,
  parameter int EIN_LIMIT = EIN_MAX_CYC
) (
  input  wire logic          core_clk,
  input  wire logic          rst_b,
  input  wire logic          clk_en,
  input  wire logic          line_zc,
  input  wire sample_t       pin_smp,
  input  wire sample_t       pout_smp,
  input  wire logic [15:0]   vout_mant,
  input  wire reg_req_t      req,
  output logic [DW-1:0]      rdata,
  output logic               irq
);

  function automatic logic [31:0] lin_scale(input logic [31:0] v,
                                            input logic [4:0]  n);
    logic [4:0] mag;
    mag = n[4] ? 5'(-n) : n;
    // negative exponents shift right arithmetically
    if (n[4]) lin_scale = 32'($signed(v) >>> mag);
    else      lin_scale = v << mag;
  endfunction : lin_scale

  // line zero-cross: three flops, change taken when last two agree
  logic [2:0] zc_sync;
  logic       zc_stable;
  logic       zc_rise;
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      zc_sync   <= 3'h0;
      zc_stable <= 1'b0;
      zc_rise   <= 1'b0;
    end else if (clk_en) begin
      zc_sync <= {zc_sync[1:0], line_zc};
      zc_rise <= 1'b0;
      if (zc_sync[1] == zc_sync[2] && zc_sync[2] != zc_stable) begin
        zc_stable <= zc_sync[2];
        zc_rise   <= zc_sync[2];
      end
    end
  end

  // input window: four line cycles, forced closed at the time limit
  logic [2:0]  ac_cnt;
  logic [31:0] ein_tmr;
  logic [31:0] eout_tmr;
  logic        ein_close;
  logic        eout_close;
  logic        win_end [2];

  always_comb begin
    ein_close  = (zc_rise && ac_cnt == AC_CYCLES - 3'h1) ||
                 ein_tmr == 32'(EIN_LIMIT - 1);
    eout_close = eout_tmr == 32'(EOUT_WIN - 1);
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      ac_cnt <= 3'h0;
    end else if (clk_en) begin
      if (ein_close) begin
        ac_cnt <= 3'h0;
      end else if (zc_rise) begin
        ac_cnt <= ac_cnt + 3'h1;
      end
    end
  end

  // time limit bounds the update period when line cycles go missing
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      ein_tmr <= 32'h0;
    end else if (clk_en) begin
      if (ein_close) begin
        ein_tmr <= 32'h0;
      end else begin
        ein_tmr <= ein_tmr + 32'h1;
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      eout_tmr <= 32'h0;
    end else if (clk_en) begin
      if (eout_close) begin
        eout_tmr <= 32'h0;
      end else begin
        eout_tmr <= eout_tmr + 32'h1;
      end
    end
  end

  // both strobes from one process, one cycle each
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      win_end[0] <= 1'b0;
      win_end[1] <= 1'b0;
    end else if (clk_en) begin
      win_end[0] <= ein_close;
      win_end[1] <= eout_close;
    end
  end

  sample_t     smp [2];
  logic [14:0] acc [2];
  logic [7:0]  roll [2];
  logic [23:0] nsmp [2];
  logic        upd [2];
  assign smp[0] = pin_smp;
  assign smp[1] = pout_smp;

  for (genvar c = 0; c < 2; c++) begin : g_ch
    logic [31:0] win_sum;
    logic [15:0] win_cnt;
    logic [31:0] quo;
    logic [16:0] rem;
    logic [15:0] dvs;
    logic [5:0]  bits;
    div_state_t  dstate;
    logic [16:0] rem_sh;
    logic [15:0] avg;
    logic [15:0] acc_sum;

    always_comb begin
      rem_sh  = {rem[15:0], quo[31]};
      avg     = quo[15:0];
      acc_sum = {1'b0, acc[c]} + avg;
    end

    // window sum; a sample at the window edge opens the next window
    always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
        win_sum <= 32'h0;
        win_cnt <= 16'h0;
      end else if (clk_en) begin
        if (win_end[c]) begin
          win_sum <= smp[c].valid ? 32'(smp[c].power) : 32'h0;
          win_cnt <= smp[c].valid ? 16'h1 : 16'h0;
        end else if (smp[c].valid) begin
          win_sum <= win_sum + 32'(smp[c].power);
          win_cnt <= win_cnt + 16'h1;
        end
      end
    end

    // serial divide: sum over count, one quotient bit a cycle
    always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
        dstate <= DIV_IDLE;
        quo    <= 32'h0;
        rem    <= 17'h0;
        dvs    <= 16'h0;
        bits   <= 6'h0;
        upd[c] <= 1'b0;
      end else if (clk_en) begin
        upd[c] <= 1'b0;
        case (dstate)
          DIV_IDLE: begin
            if (win_end[c] && win_cnt != 16'h0) begin
              quo    <= win_sum;
              rem    <= 17'h0;
              dvs    <= win_cnt;
              bits   <= 6'h0;
              dstate <= DIV_RUN;
            end
          end
          DIV_RUN: begin
            if (rem_sh >= {1'b0, dvs}) begin
              rem <= rem_sh - {1'b0, dvs};
              quo <= {quo[30:0], 1'b1};
            end else begin
              rem <= rem_sh;
              quo <= {quo[30:0], 1'b0};
            end
            bits <= bits + 6'h1;
            if (bits == DIV_LAST) begin
              dstate <= DIV_IDLE;
              upd[c] <= 1'b1;
            end
          end
          default: dstate <= DIV_IDLE;
        endcase
      end
    end

    // average never exceeds fifteen bits, so at most one wrap per add
    always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
        acc[c]  <= 15'h0;
        roll[c] <= 8'h0;
        nsmp[c] <= 24'h0;
      end else if (clk_en && upd[c]) begin
        acc[c]  <= acc_sum[14:0];
        nsmp[c] <= nsmp[c] + 24'h1;
        if (acc_sum > {1'b0, ACC_MAX}) begin
          roll[c] <= roll[c] + 8'h1;
        end
      end
    end
  end

  // register file
  logic [15:0]    lin_word;
  logic [31:0]    lin_value;
  logic [31:0]    vout_volts;
  logic [3:0]     eff_idx;
  logic [23:0]    snap_n [2];
  logic [NST-1:0] status;
  logic [NST-1:0] mask;
  logic [NST-1:0] st_evt;
  logic [DW-1:0]  next_rdata;
  logic           cml_bad;
  logic           rd_status;
  logic           vmode_wr;
  logic [7:0]     eff_byte;

  always_comb begin
    lin_value  = lin_scale(32'($signed(lin_word[10:0])),
                           lin_word[15:11]);
    vout_volts = lin_scale({16'h0, vout_mant}, VOUT_EXP);
    rd_status  = req.rd && req.addr == A_STATUS;
    vmode_wr   = req.wr && req.addr == A_VOUT_MODE;
    // index past the last byte reads back zero
    eff_byte   = (int'(eff_idx) < EFF_BYTES) ? EFF_DEFAULT[eff_idx] : 8'h00;
    st_evt          = '0;
    st_evt[ST_EIN]  = upd[0];
    st_evt[ST_EOUT] = upd[1];
    st_evt[ST_CML]  = vmode_wr;
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      lin_word <= 16'h0;
    end else if (clk_en && req.wr && req.addr == A_LIN_IN) begin
      lin_word <= req.wdata[15:0];
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      mask <= '0;
    end else if (clk_en && req.wr && req.addr == A_MASK) begin
      mask <= req.wdata[NST-1:0];
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      eff_idx <= 4'h0;
    end else if (clk_en && req.wr && req.addr == A_EFF_HL) begin
      eff_idx <= req.wdata[3:0];
    end
  end

  // voltage mode is read only; a write is dropped and flagged
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      cml_bad <= 1'b0;
    end else if (clk_en) begin
      if (vmode_wr) begin
        cml_bad <= 1'b1;
      end else if (req.wr && req.addr == A_CML &&
                   req.wdata[CML_INVALID]) begin
        cml_bad <= 1'b0;
      end
    end
  end

  // sticky events; a new event beats the clearing read
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      status <= '0;
    end else if (clk_en) begin
      status <= (rd_status ? '0 : status) | st_evt;
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      irq <= 1'b0;
    end else if (clk_en) begin
      irq <= |(status & mask);
    end
  end

  // read mux; unmapped or idle cycles give zero
  always_comb begin
    next_rdata = '0;
    if (req.rd) begin
      if (req.addr == A_EIN) begin
        next_rdata = {BLK_COUNT, roll[0], 1'b0, acc[0]};
      end else if (req.addr == A_EOUT) begin
        next_rdata = {BLK_COUNT, roll[1], 1'b0, acc[1]};
      end else if (req.addr == A_EIN_N) begin
        next_rdata = {8'h00, snap_n[0]};
      end else if (req.addr == A_EOUT_N) begin
        next_rdata = {8'h00, snap_n[1]};
      end else if (req.addr == A_COEFF) begin
        next_rdata = {8'h00, COEF_B, COEF_R, COEF_M};
      end else if (req.addr == A_VOUT_MODE) begin
        next_rdata = {24'h0, MODE_LINEAR, VOUT_EXP};
      end else if (req.addr == A_VOUT) begin
        next_rdata = vout_volts;
      end else if (req.addr == A_CML) begin
        next_rdata = 32'(cml_bad) << CML_INVALID;
      end else if (req.addr == A_EFF_HL) begin
        next_rdata = {23'h0, eff_idx == EFF_LAST, eff_byte};
      end else if (req.addr == A_LIN_IN) begin
        next_rdata = {16'h0, lin_word};
      end else if (req.addr == A_LIN_OUT) begin
        next_rdata = lin_value;
      end else if (req.addr == A_STATUS) begin
        next_rdata = 32'(status);
      end else if (req.addr == A_MASK) begin
        next_rdata = 32'(mask);
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      rdata <= '0;
    end else if (clk_en) begin
      rdata <= next_rdata;
    end
  end

  // count taken at the same edge as the energy word, so they always pair
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      snap_n[0] <= 24'h0;
      snap_n[1] <= 24'h0;
    end else if (clk_en && req.rd) begin
      if (req.addr == A_EIN) begin
        snap_n[0] <= nsmp[0];
      end else if (req.addr == A_EOUT) begin
        snap_n[1] <= nsmp[1];
      end
    end
  end

endmodule : energy_accum
`default_nettype wire

// ---- testbench/energy_accum_properties.sv ----
// Purpose: port-level properties of energy_accum
// Assumes: one clock domain, asynchronous active-low reset
// Notes:   bound to every energy_accum instance
`timescale 1ns/1ps
`default_nettype none
module energy_accum_chk
  import energy_pkg::*;
(
  input wire logic          core_clk,
  input wire logic          rst_b,
  input wire logic          clk_en,
  input wire reg_req_t      req,
  input wire logic [DW-1:0] rdata,
  input wire logic          irq
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  wire logic rd_on = clk_en && req.rd;
  property p_rd_idle; clk_en && !req.rd |=> rdata == '0; endproperty
  a_rd_idle: assert property (p_rd_idle)
    else $error("read data outside read slot");
  property p_vmode;
    rd_on && req.addr == A_VOUT_MODE |=> rdata == {MODE_LINEAR, VOUT_EXP};
  endproperty
  a_vmode: assert property (p_vmode)
    else $error("voltage mode byte wrong");
  property p_coeff;
    rd_on && req.addr == A_COEFF |=> rdata == {8'h00, COEF_B, COEF_R, COEF_M};
  endproperty
  a_coeff: assert property (p_coeff)
    else $error("coefficients wrong");
  property p_ein_fmt;
    rd_on && req.addr == A_EIN |=> rdata[31:24] == BLK_COUNT && !rdata[15];
  endproperty
  a_ein_fmt: assert property (p_ein_fmt)
    else $error("input energy word malformed");
  property p_eout_fmt;
    rd_on && req.addr == A_EOUT |=> rdata[31:24] == BLK_COUNT && !rdata[15];
  endproperty
  a_eout_fmt: assert property (p_eout_fmt)
    else $error("output energy word malformed");
  property p_eff;
    rd_on && req.addr == A_EFF_HL |=> rdata[31:9] == '0 && rdata[7:0] == '0;
  endproperty
  a_eff: assert property (p_eff)
    else $error("efficiency byte malformed");
  property p_unmap; rd_on && req.addr == 10'h004 |=> rdata == '0; endproperty
  a_unmap: assert property (p_unmap)
    else $error("unmapped read not zero");
  property p_mask_off;
    clk_en && req.wr && req.addr == A_MASK && req.wdata[NST-1:0] == '0
      ##1 clk_en |=> !irq;
  endproperty
  a_mask_off: assert property (p_mask_off)
    else $error("interrupt despite empty mask");
  property p_freeze; !clk_en |=> $stable(rdata) && $stable(irq); endproperty
  a_freeze: assert property (p_freeze)
    else $error("outputs moved while disabled");
  c_ein: cover property (rd_on && req.addr == A_EIN);
  c_irq: cover property ($rose(irq));
  c_vwr: cover property (clk_en && req.wr && req.addr == A_VOUT_MODE);
endmodule : energy_accum_chk
bind energy_accum energy_accum_chk energy_accum_chk_i (
  .core_clk(core_clk), .rst_b(rst_b), .clk_en(clk_en),
  .req(req), .rdata(rdata), .irq(irq));
`default_nettype wire

// ---- testbench/power_source.sv ----
// Purpose: model of the mains line and power sensors feeding the block
// Assumes: square zero-cross wave, one sample every enabled cycle
// Notes:   constant levels make every window average exact
`timescale 1ns/1ps
`default_nettype none
module power_source
  import energy_pkg::*;
#(
  parameter int HALF = 25
) (
  input  wire logic        core_clk,
  input  wire logic        rst_b,
  input  wire logic        run,
  input  wire logic [14:0] pin_lvl,
  input  wire logic [14:0] pout_lvl,
  output logic             line_zc,
  output sample_t          pin_smp,
  output sample_t          pout_smp
);
  int ph;
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      ph <= 0;
      line_zc <= 1'b0;
    end else if (run) begin
      ph <= (ph == HALF - 1) ? 0 : ph + 1;
      if (ph == HALF - 1) line_zc <= !line_zc;
    end
  end
  // idle samples show garbage so a stray capture is caught
  assign pin_smp  = '{valid: run, power: run ? pin_lvl : ~pin_lvl};
  assign pout_smp = '{valid: run, power: run ? pout_lvl : ~pout_lvl};
endmodule : power_source
`default_nettype wire

// ---- testbench/testbench.sv ----
// Purpose: self-checking bench for energy_accum
// Assumes: shortened windows, constant levels from power_source
// Notes:   register port driven right after rising edges
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin \
  $display("[FAIL] %s exp %0h got %0h", nm, e, g); err_count++; end end
module testbench
  import energy_pkg::*;
;
  localparam logic [14:0] PIN  = 15'h3000;
  localparam logic [14:0] POUT = 15'h7FFF;
  logic          core_clk  = 1'b0;
  logic          rst_b     = 1'b0;
  logic          clk_en    = 1'b1;
  logic          run       = 1'b0;
  logic          line_zc;
  sample_t       pin_smp;
  sample_t       pout_smp;
  logic [15:0]   vout_mant = 16'h1200;
  reg_req_t      req       = '0;
  logic [DW-1:0] rdata;
  logic          irq;
  logic [DW-1:0] d;
  int            err_count = 0;
  int            compares  = 0;
  int            ex;
  longint        tot;
  always #12.5 core_clk = !core_clk;
  power_source #(.HALF(25)) power_source_i (.core_clk(core_clk),
    .rst_b(rst_b), .run(run), .pin_lvl(PIN), .pout_lvl(POUT),
    .line_zc(line_zc), .pin_smp(pin_smp), .pout_smp(pout_smp));
  energy_accum #(.EOUT_WIN(100), .EIN_LIMIT(400)) energy_accum_i (
    .core_clk(core_clk), .rst_b(rst_b), .clk_en(clk_en),
    .line_zc(line_zc), .pin_smp(pin_smp), .pout_smp(pout_smp),
    .vout_mant(vout_mant), .req(req), .rdata(rdata), .irq(irq));
  task automatic wr(input logic [AW-1:0] a, input logic [DW-1:0] v);
    @(posedge core_clk) req <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
    @(posedge core_clk) req.wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [AW-1:0] a);
    @(posedge core_clk) req <= '{addr: a, wdata: '0, wr: 1'b0, rd: 1'b1};
    @(posedge core_clk) req.rd <= 1'b0;
    @(posedge core_clk) d = rdata;
  endtask : rd
  task automatic wait_irq();
    int n;
    n = 0;
    while (irq !== 1'b1 && n < 400) begin
      @(posedge core_clk);
      n++;
    end
    `CHK("irq", 1'b1, irq)
  endtask : wait_irq
  // snapshot first, then the count that belongs to it
  task automatic chk_acc(input logic [AW-1:0] a, input logic [AW-1:0] an,
                         input logic [14:0] p);
    logic [DW-1:0] v;
    rd(a);
    v = d;
    rd(an);
    tot = longint'(d[23:0]) * p;
    `CHK("acc", tot[14:0], v[14:0])
    `CHK("roll", tot[22:15], v[23:16])
    `CHK("count", 1'b1, d[23:0] != 24'h0)
  endtask : chk_acc
  task automatic end_of_test();
    $display("compares %0d err_count %0d", compares, err_count);
    if (err_count == 0 && compares > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : end_of_test
  initial begin
    #1_500_000;
    err_count++;
    end_of_test();
  end
  initial begin
    repeat (20) @(posedge core_clk);
    rst_b <= 1'b1;
    rd(A_EIN);
    `CHK("ein0", {BLK_COUNT, 24'h0}, d)
    rd(A_EIN_N);
    `CHK("n0", 32'h0, d)
    rd(A_COEFF);
    `CHK("coeff", 32'h1, d)
    wr(A_MASK, 32'h4);
    wr(A_VOUT_MODE, 32'hFF);
    rd(A_VOUT_MODE);
    `CHK("vmode", {24'h0, 3'h0, 5'h17}, d)
    rd(A_CML);
    `CHK("cml", 1'b1, d[6])
    `CHK("irq_v", 1'b1, irq)
    rd(A_STATUS);
    `CHK("st_v", 32'h4, d)
    wr(A_MASK, 32'h0);
    rd(10'h004);
    `CHK("unmap", 32'h0, d)
    rd(A_VOUT);
    `CHK("vout", 32'h9, d)
    vout_mant <= 16'hFFFF;
    rd(A_VOUT);
    `CHK("vout_max", 32'h7F, d)
    for (int n = 0; n < 32; n++) begin
      wr(A_LIN_IN, {16'h0, 5'(n), 11'h7FD});
      rd(A_LIN_OUT);
      ex = (n < 16) ? (-3 <<< n) : (-3 >>> (32 - n));
      `CHK("lin", DW'(ex), d)
    end
    wr(A_EFF_HL, 32'hD);
    rd(A_EFF_HL);
    `CHK("eff13", 32'h100, d)
    wr(A_EFF_HL, 32'hC);
    rd(A_EFF_HL);
    `CHK("eff12", 32'h0, d)
    wr(A_MASK, 32'h1);
    @(posedge core_clk) run <= 1'b1;
    wait_irq();
    rd(A_STATUS);
    `CHK("st_ein", 1'b1, d[0])
    chk_acc(A_EIN, A_EIN_N, PIN);
    wr(A_MASK, 32'h0);
    @(posedge core_clk) clk_en <= 1'b0;
    @(posedge core_clk) clk_en <= 1'b1;
    // poll slower than one accumulator wrap so the rollover counter is exercised
    repeat (300) begin
      repeat (100) @(posedge core_clk);
      chk_acc(A_EOUT, A_EOUT_N, POUT);
    end
    `CHK("wrapped", 1'b1, d[23:0] > 24'h100)
    rd(A_STATUS);
    `CHK("st_eout", 1'b1, d[1])
    chk_acc(A_EIN, A_EIN_N, PIN);
    end_of_test();
  end
endmodule : testbench
`default_nettype wire
